//--- hw/bpsrc_pkg.sv
// Constants and types shared by the power state and reset control block.
// Assumes a single 10 MHz clock and a synchronous, active-low reset.
package bpsrc_pkg;

    // ************************************************************
    // Register map (byte offsets, one 32-bit word each)
    // ************************************************************
    localparam logic [7:0] REG_PM    = 8'h00;
    localparam logic [7:0] REG_BCTL  = 8'h04;
    localparam logic [7:0] REG_DIAG  = 8'h08;
    localparam logic [7:0] REG_CMASK = 8'h0C;
    localparam logic [7:0] REG_STAT  = 8'h10;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam logic [1:0]  PS_D0     = 2'h0;
    localparam logic [1:0]  PS_D1     = 2'h1;
    localparam logic [1:0]  PS_D2     = 2'h2;
    localparam logic [1:0]  PS_D3HOT  = 2'h3;
    localparam int          BCTL_SRST = 0;
    localparam int          DIAG_CHIP = 0;
    localparam logic [15:0] CMASK_RST = 16'h0000;

    // ************************************************************
    // Clock period, mask width and cycle counts
    // ************************************************************
    localparam int         CLK_PERIOD_NS = 100;
    localparam int         MASK_BITS     = 16;
    localparam logic [4:0] ACC_WAIT_CLKS = 5'h10;
    localparam logic [4:0] CHIP_CLR_LAST = 5'h13;
    localparam logic [4:0] SHIFT_LAST    = 5'h16;
    localparam logic [4:0] MASK_FIRST    = 5'h03;
    localparam logic [4:0] MASK_LAST     = 5'h12;

    typedef enum logic [1:0] {ST_SHIFT, ST_HOLD, ST_RUN} bpsrc_state_e;

endpackage

//--- hw/bpsrc_shift_if.sv
// Handshake between the sequencer and the clock mask shifter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface bpsrc_shift_if;
    logic        go;
    logic        busy;
    logic        done;
    logic [15:0] mask;
    modport ctl (output go, input busy, input done, input mask);
    modport eng (input go, output busy, output done, output mask);
endinterface

//--- hw/bpsrc_mask_shift.sv
// Serial loader for the secondary clock mask.
// Assumes an external load/shift register clocked with CLK and fed by the load control pin.
`timescale 1ns/1ns
module bpsrc_mask_shift
    import bpsrc_pkg::*;
#(
    parameter int MBITS = MASK_BITS
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Sequencer side
    bpsrc_shift_if.eng sh,
    // Pins
    input  wire logic clock_mask_serial_in,
    output logic      sr_shift,
    output logic      sr_oe_n
);
    if (MBITS != 16) begin : g_chk
        $error("mask width must be 16");
    end

    logic [1:0]       msk_sync_reg;
    logic [4:0]       cnt_reg;
    logic             busy_reg;
    logic             done_reg;
    logic [MBITS-1:0] mask_reg;
    wire              last    = busy_reg && cnt_reg == SHIFT_LAST;
    wire              capture = busy_reg && cnt_reg >= MASK_FIRST && cnt_reg <= MASK_LAST;

    // ************************************************************
    // Load one cycle, then shift; MSB arrives first
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            msk_sync_reg <= 2'h0;
            cnt_reg      <= 5'h00;
            busy_reg     <= 1'b0;
            done_reg     <= 1'b0;
            mask_reg     <= CMASK_RST;
        end else begin
            msk_sync_reg <= {msk_sync_reg[0], clock_mask_serial_in};
            done_reg     <= last;
            if (sh.go && !busy_reg) begin
                busy_reg <= 1'b1;
                cnt_reg  <= 5'h00;
            end else if (busy_reg) begin
                cnt_reg  <= cnt_reg + 5'h01;
                busy_reg <= !last;
            end
            if (capture) begin
                mask_reg <= {mask_reg[MBITS-2:0], msk_sync_reg[1]};
            end
        end
    end

    assign sr_shift = busy_reg && cnt_reg != 5'h00;
    assign sr_oe_n  = !busy_reg;
    assign sh.busy  = busy_reg;
    assign sh.done  = done_reg;
    assign sh.mask  = mask_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    a_shift_len_23: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(busy_reg) |-> ##22 (busy_reg && cnt_reg == SHIFT_LAST) ##1 (!busy_reg && done_reg))
        else $error("mask shift did not take 23 cycles");
    c_shift_done: cover property (@(posedge clk) disable iff (!rst_n) done_reg);

endmodule

//--- hw/bpsrc_top.sv
// Power state handling and reset sequencing of a two-bus bridge.
// Assumes a register master with one-cycle strobes and a 10 MHz clock.
`timescale 1ns/1ns

module bpsrc_top
    import bpsrc_pkg::*;
#(
    parameter int AW = 8
) (
    // Clock and reset
    input  wire logic          CLK,
    input  wire logic          RST_N,
    // Register port
    input  wire logic [AW-1:0] ADDR,
    input  wire logic [31:0]   WDATA,
    input  wire logic          WR,
    input  wire logic          RD,
    output logic      [31:0]   RDATA,
    output logic               CFG_READY,
    // Clock mask loader pins
    input  wire logic          CLOCK_MASK_SERIAL_IN,
    output logic               SR_SHIFT,
    output logic               SR_OE_N,
    // Secondary clocks
    input  wire logic          CLOCK_STOP_ON_OFF_STATE_ENABLE,
    output logic      [9:0]    SECONDARY_CLOCK_OUT_EN,
    output logic               SEC_BUS_B2,
    // Reset and bus control
    output logic               SEC_RESET_N,
    output logic               PRI_FLOAT,
    output logic               SEC_CTRL_FLOAT,
    output logic               SEC_ADDR_DATA_LOW,
    output logic               BUF_CLEAR
);
    if (AW < 5) begin : g_chk
        $error("address too narrow for the register map");
    end

    // ************************************************************
    // State
    // ************************************************************
    bpsrc_state_e st_reg;
    logic [1:0]   stop_sync_reg;
    logic [1:0]   pstate_reg;
    logic         srst_bit_reg;
    logic         chip_reg;
    logic [15:0]  cmask_reg;
    logic [4:0]   acc_cnt_reg;
    logic [4:0]   chip_cnt_reg;
    logic         go_reg;
    logic [31:0]  rdata_reg;
    logic [9:0]   clk_en_reg;
    logic         srst_n_reg;
    logic         pri_float_reg;
    logic         ctrl_float_reg;
    logic         ad_low_reg;
    logic         buf_clr_reg;
    logic         b2_reg;

    bpsrc_shift_if sh ();

    bpsrc_mask_shift #(.MBITS(MASK_BITS)) u_shift (
        .clk      (CLK),
        .rst_n    (RST_N),
        .sh       (sh.eng),
        .clock_mask_serial_in   (CLOCK_MASK_SERIAL_IN),
        .sr_shift (SR_SHIFT),
        .sr_oe_n  (SR_OE_N)
    );

    // Slots enable if either presence bit is low; devices enable on a low bit
    function automatic logic [9:0] clk_map(input logic [15:0] m);
        logic [9:0] e;
        e = 10'h000;
        for (int i = 0; i < 4; i++) begin
            e[i] = !(m[2*i] && m[2*i+1]);
        end
        for (int j = 0; j < 5; j++) begin
            e[4+j] = !m[8+j];
        end
        e[9] = !m[13];
        return e;
    endfunction

    // ************************************************************
    // Decode
    // ************************************************************
    wire       sel_pm     = ADDR == AW'(REG_PM);
    wire       sel_bctl   = ADDR == AW'(REG_BCTL);
    wire       sel_diag   = ADDR == AW'(REG_DIAG);
    wire       sel_cmask  = ADDR == AW'(REG_CMASK);
    wire       sel_stat   = ADDR == AW'(REG_STAT);
    wire       accessible = acc_cnt_reg == ACC_WAIT_CLKS && !chip_reg;
    wire       wr_ok      = WR && accessible;
    wire [1:0] ps_wr      = WDATA[1:0];
    wire       ps_legal   = ps_wr == PS_D0 || ps_wr == PS_D3HOT;
    wire       wake       = wr_ok && sel_pm && pstate_reg == PS_D3HOT && ps_wr == PS_D0;
    wire       chip_set   = wr_ok && sel_diag && WDATA[DIAG_CHIP];
    wire       soft_rst   = wake || chip_set;
    // Only the secondary reset bit stays writable while a chip reset is pending
    wire       bctl_ok    = WR && sel_bctl && (accessible || st_reg == ST_HOLD);
    wire       srst_clr   = bctl_ok && st_reg == ST_HOLD && !WDATA[BCTL_SRST];
    wire       sec_rst    = st_reg != ST_RUN || srst_bit_reg;
    wire       clk_stop   = pstate_reg == PS_D3HOT && stop_sync_reg[1];
    wire [3:0] stat_bits  = {clk_stop, accessible, sh.busy, sec_rst};
    wire [31:0] rd_val    = sel_pm    ? {30'h0, pstate_reg} :
                            sel_bctl  ? {31'h0, srst_bit_reg} :
                            sel_diag  ? {31'h0, chip_reg} :
                            sel_cmask ? {16'h0, cmask_reg} :
                            sel_stat  ? {28'h0, stat_bits} : 32'h0;
    wire       rd_ok      = accessible || (st_reg == ST_HOLD && sel_bctl);

    assign sh.go = go_reg;

    // ************************************************************
    // Sequencer and control registers
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_reg        <= ST_SHIFT;
            stop_sync_reg <= 2'h0;
            pstate_reg    <= PS_D0;
            srst_bit_reg  <= 1'b0;
            chip_reg      <= 1'b0;
            cmask_reg     <= CMASK_RST;
            acc_cnt_reg   <= 5'h00;
            chip_cnt_reg  <= 5'h00;
            go_reg        <= 1'b1;
        end else begin
            stop_sync_reg <= {stop_sync_reg[0], CLOCK_STOP_ON_OFF_STATE_ENABLE};
            go_reg        <= 1'b0;
            if (acc_cnt_reg != ACC_WAIT_CLKS) begin
                acc_cnt_reg <= acc_cnt_reg + 5'h01;
            end
            if (soft_rst) begin
                pstate_reg   <= PS_D0;
                cmask_reg    <= CMASK_RST;
                srst_bit_reg <= chip_set;
                chip_reg     <= chip_set;
                chip_cnt_reg <= 5'h00;
                if (chip_set) begin
                    st_reg <= ST_HOLD;
                end
            end else begin
                if (wr_ok && sel_pm && ps_legal) begin
                    pstate_reg <= ps_wr;
                end
                if (wr_ok && sel_cmask) begin
                    cmask_reg <= WDATA[15:0];
                end
                if (bctl_ok) begin
                    srst_bit_reg <= WDATA[BCTL_SRST];
                end
                case (st_reg)
                    ST_SHIFT: begin
                        if (sh.done) begin
                            cmask_reg <= sh.mask;
                            st_reg    <= ST_RUN;
                        end
                    end
                    ST_HOLD: begin
                        if (srst_clr) begin
                            st_reg <= ST_SHIFT;
                            go_reg <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
                // Count from the clearing write itself so the bit is gone within 20 clocks
                if (chip_reg && (st_reg != ST_HOLD || srst_clr)) begin
                    chip_cnt_reg <= chip_cnt_reg + 5'h01;
                    if (chip_cnt_reg == CHIP_CLR_LAST) begin
                        chip_reg <= 1'b0;
                    end
                end
            end
        end
    end

    // ************************************************************
    // Pin controls and read data
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rdata_reg      <= 32'h0;
            clk_en_reg     <= 10'h000;
            srst_n_reg     <= 1'b0;
            pri_float_reg  <= 1'b1;
            ctrl_float_reg <= 1'b1;
            ad_low_reg     <= 1'b1;
            buf_clr_reg    <= 1'b1;
            b2_reg         <= 1'b0;
        end else begin
            rdata_reg      <= (RD && rd_ok) ? rd_val : 32'h0;
            clk_en_reg     <= clk_stop ? 10'h000 : clk_map(cmask_reg);
            srst_n_reg     <= !sec_rst;
            pri_float_reg  <= chip_reg || chip_set;
            ctrl_float_reg <= sec_rst || chip_reg;
            ad_low_reg     <= sec_rst;
            buf_clr_reg    <= sec_rst || soft_rst;
            b2_reg         <= pstate_reg == PS_D3HOT;
        end
    end

    // Wake events are routed around the bridge on the board; nothing here carries them

    assign RDATA                  = rdata_reg;
    assign CFG_READY              = accessible;
    assign SECONDARY_CLOCK_OUT_EN = clk_en_reg;
    assign SEC_BUS_B2             = b2_reg;
    assign SEC_RESET_N            = srst_n_reg;
    assign PRI_FLOAT              = pri_float_reg;
    assign SEC_CTRL_FLOAT         = ctrl_float_reg;
    assign SEC_ADDR_DATA_LOW      = ad_low_reg;
    assign BUF_CLEAR              = buf_clr_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    a_pstate_legal: assert property (pstate_reg == PS_D0 || pstate_reg == PS_D3HOT)
        else $error("power state holds an unimplemented code");
    a_mid_dropped: assert property (
        wr_ok && sel_pm && !ps_legal && !soft_rst |=> pstate_reg == $past(pstate_reg))
        else $error("intermediate power state write was taken");
    a_hot_off_b2: assert property (pstate_reg == PS_D3HOT |=> SEC_BUS_B2)
        else $error("hot off without B2");
    a_clock_stop: assert property (clk_stop |=> SECONDARY_CLOCK_OUT_EN == 10'h000)
        else $error("secondary clocks running in hot off");
    a_wake_no_srst: assert property (
        wake && !sec_rst |=> SEC_RESET_N && pstate_reg == PS_D0 ##1 SEC_RESET_N)
        else $error("wake from hot off touched secondary reset");
    a_reset_float: assert property ($rose(RST_N) |-> PRI_FLOAT && SEC_CTRL_FLOAT)
        else $error("bus not floated at reset");
    a_cfg_wait16: assert property (
        $rose(RST_N) |-> !CFG_READY[*8] ##1 !CFG_READY[*8] ##1 CFG_READY)
        else $error("configuration ready not 16 cycles after reset");
    a_srst_held: assert property ($rose(RST_N) |-> !SEC_RESET_N[*8])
        else $error("secondary reset released with primary reset");
    a_srst_bit: assert property (srst_bit_reg |=> !SEC_RESET_N)
        else $error("secondary reset bit set but reset released");
    a_ad_low: assert property (!SEC_RESET_N |-> SEC_ADDR_DATA_LOW && SEC_CTRL_FLOAT)
        else $error("secondary lines not parked during reset");
    a_buf_clear: assert property (!SEC_RESET_N |-> BUF_CLEAR)
        else $error("buffers not cleared during secondary reset");
    a_bit_access: assert property (
        srst_bit_reg && st_reg == ST_RUN && !chip_reg && acc_cnt_reg == ACC_WAIT_CLKS
        && RD && sel_bctl |-> CFG_READY ##1 RDATA[BCTL_SRST])
        else $error("bridge inaccessible during bit-driven reset");
    a_chip_sets: assert property (
        chip_set |=> chip_reg && srst_bit_reg && st_reg == ST_HOLD ##1 !SEC_RESET_N && PRI_FLOAT)
        else $error("chip reset did not set secondary reset bit");
    a_chip_clear: assert property (srst_clr |-> ##[1:20] !chip_reg)
        else $error("chip reset bit not cleared within 20 cycles");
    a_shift_gate: assert property (st_reg == ST_SHIFT |=> !SEC_RESET_N)
        else $error("secondary reset released before mask shift end");

    c_wake:       cover property (wake);
    c_chip_cycle: cover property (srst_clr ##[1:30] st_reg == ST_RUN);
    c_srst_rel:   cover property ($rose(SEC_RESET_N));
    c_hot_off:    cover property (clk_stop);

endmodule

//--- bench/bpsrc_mask_src.sv
// Model of the external load/shift register that feeds the clock mask pin.
// Assumes it is clocked by the block clock and steered by the shift control pins.
`timescale 1ns/1ns
module bpsrc_mask_src (
    // Clock
    input  wire logic        clk,
    // Control from the block
    input  wire logic        shift,
    input  wire logic        oe_n,
    // Parallel mask presented at load time
    input  wire logic [15:0] mask,
    // Serial output
    output logic             serial_out
);
    logic [15:0] sreg;

    initial begin
        sreg       = 16'h0000;
        serial_out = 1'b0;
    end

    // Load on the low control cycle, then shift MSB first; bit k shows at count 16-k
    always @(posedge clk) begin
        if (oe_n === 1'b0 && shift === 1'b0) begin
            sreg       <= mask;
            serial_out <= mask[15];
        end else if (oe_n === 1'b0 && shift === 1'b1) begin
            sreg       <= {sreg[14:0], ~sreg[0]};
            serial_out <= sreg[14];
        end else begin
            // Outside the shift window the pin carries no data, so it toggles
            serial_out <= ~serial_out;
        end
    end
endmodule

//--- bench/bpsrc_tb.sv
// Self-checking bench for the power state and reset control block.
// Assumes the design files and package are compiled first.
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("unexpected %s expected %h seen %h", nm, exp, got); \
        end \
    end
module testbench
    import bpsrc_pkg::*;
;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} bpsrc_row_s;

    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, stop_en = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rv;
    logic [15:0] feed_mask = 16'hD5D2;
    logic        ser, sr_shift, sr_oe_n, b2, srst_n, pfloat, cfloat, adlow, bclr, ready;
    logic [9:0]  clk_en;
    int          num_errors = 0, tests_run = 0, n, lows, rdy, seen;
    bpsrc_row_s  rows[8];

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    bpsrc_top #(.AW(8)) dut_u (
        .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .CFG_READY(ready), .CLOCK_MASK_SERIAL_IN(ser),
        .SR_SHIFT(sr_shift), .SR_OE_N(sr_oe_n),
        .CLOCK_STOP_ON_OFF_STATE_ENABLE(stop_en), .SECONDARY_CLOCK_OUT_EN(clk_en),
        .SEC_BUS_B2(b2), .SEC_RESET_N(srst_n), .PRI_FLOAT(pfloat),
        .SEC_CTRL_FLOAT(cfloat), .SEC_ADDR_DATA_LOW(adlow), .BUF_CLEAR(bclr)
    );

    bpsrc_mask_src feed_u (
        .clk(clk), .shift(sr_shift), .oe_n(sr_oe_n), .mask(feed_mask), .serial_out(ser)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic complete_run();
        if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Bounded wait for configuration access to come back
    task automatic wait_ready();
        for (n = 0; n < 60 && ready !== 1'b1; n++) tick(1);
        if (n == 60) begin num_errors++; complete_run(); end
    endtask

    // Walk from a release until the secondary reset lifts, timing the shift and access
    task automatic watch_release(input int lim);
        lows = 0; rdy = 0;
        for (n = 1; n < lim && srst_n !== 1'b1; n++) begin
            tick(1);
            if (sr_oe_n === 1'b0) lows++;
            if (ready === 1'b1 && rdy == 0) rdy = n;
        end
        if (n == lim) begin num_errors++; complete_run(); end
    endtask

    function automatic logic [9:0] exp_en(input logic [15:0] m);
        logic [9:0] e;
        for (int i = 0; i < 4; i++) e[i] = ~&m[2*i+:2];
        for (int j = 0; j < 5; j++) e[4+j] = ~m[8+j];
        e[9] = ~m[13];
        return e;
    endfunction

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rows = '{'{REG_PM, 1, 32'h1, 32'h0}, '{REG_PM, 1, 32'h2, 32'h0},
                 '{REG_CMASK, 0, 32'h0, 32'hD5D2}, '{REG_STAT, 0, 32'h0, 32'h4},
                 '{REG_CMASK, 1, 32'h1234, 32'h1234}, '{REG_CMASK, 1, 32'hD5D2, 32'hD5D2},
                 '{8'h20, 1, 32'hFFFF_FFFF, 32'h0}, '{REG_DIAG, 0, 32'h0, 32'h0}};
        tick(11);
        `CHK("sec_reset_in_reset", 1'b0, srst_n)
        `CHK("float_in_reset", 1'b1, pfloat)
        `CHK("ctrl_float_in_reset", 1'b1, cfloat)
        `CHK("ready_in_reset", 1'b0, ready)
        @(posedge clk);
        rst_n <= 1'b1;
        watch_release(80);
        `CHK("ready_delay", 1'b1, rdy >= 16 && rdy <= 17)
        `CHK("shift_cycles", 23, lows)
        `CHK("float_after", 1'b0, pfloat)
        `CHK("clock_enables", exp_en(16'hD5D2), clk_en)
        foreach (rows[i]) begin
            if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, rv);
            `CHK("row_read", rows[i].e, rv)
        end
        // Secondary reset from the control bit
        wr_reg(REG_BCTL, 32'h1);
        tick(3);
        `CHK("bit_sec_reset", 1'b0, srst_n)
        `CHK("bit_ctrl_float", 1'b1, cfloat)
        `CHK("bit_ad_low", 1'b1, adlow)
        `CHK("bit_buf_clear", 1'b1, bclr)
        `CHK("bit_ready", 1'b1, ready)
        rd_reg(REG_BCTL, rv);
        `CHK("bit_read", 32'h1, rv)
        tick(30);
        `CHK("bit_still_reset", 1'b0, srst_n)
        wr_reg(REG_BCTL, 32'h0);
        tick(4);
        `CHK("bit_released", 1'b1, srst_n)
        `CHK("bit_ad_free", 1'b0, adlow)
        // Hot off with the stop pin allowing, then wake
        wr_reg(REG_PM, {30'h0, PS_D3HOT});
        tick(3);
        `CHK("hot_b2", 1'b1, b2)
        `CHK("hot_clocks", 10'h000, clk_en)
        wr_reg(REG_PM, {30'h0, PS_D0});
        seen = 0; lows = 0;
        // The clear pulse stands only in the cycle right after the waking write
        #1;
        for (n = 0; n < 4; n++) begin
            if (bclr === 1'b1) seen = 1;
            if (srst_n !== 1'b1) lows = 1;
            tick(1);
        end
        `CHK("wake_buf_clear", 1, seen)
        `CHK("wake_no_sec_reset", 0, lows)
        `CHK("wake_b2", 1'b0, b2)
        `CHK("wake_clocks", 10'h3FF, clk_en)
        wait_ready();
        rd_reg(REG_CMASK, rv);
        `CHK("wake_mask", 32'h0, rv)
        // Hot off with the stop pin forbidding it
        @(posedge clk);
        stop_en <= 1'b0;
        tick(4);
        wr_reg(REG_PM, {30'h0, PS_D3HOT});
        tick(3);
        `CHK("hold_b2", 1'b1, b2)
        `CHK("hold_clocks", 10'h3FF, clk_en)
        wr_reg(REG_PM, {30'h0, PS_D0});
        wait_ready();
        // Chip reset through the diagnostic bit
        feed_mask <= 16'h2AC3;
        wr_reg(REG_DIAG, 32'h1);
        tick(2);
        `CHK("chip_sec_reset", 1'b0, srst_n)
        `CHK("chip_ready", 1'b0, ready)
        `CHK("chip_float", 1'b1, cfloat)
        rd_reg(REG_BCTL, rv);
        `CHK("chip_srst_bit", 32'h1, rv)
        rd_reg(REG_DIAG, rv);
        `CHK("chip_refused", 32'h0, rv)
        tick(30);
        `CHK("chip_held", 1'b0, srst_n)
        wr_reg(REG_BCTL, 32'h0);
        watch_release(80);
        `CHK("chip_clear_delay", 1'b1, rdy >= 1 && rdy <= 20)
        `CHK("chip_shift", 23, lows)
        wait_ready();
        rd_reg(REG_CMASK, rv);
        `CHK("chip_mask", 32'h2AC3, rv)
        `CHK("chip_enables", exp_en(16'h2AC3), clk_en)
        // Primary reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        tick(3);
        `CHK("mid_sec_reset", 1'b0, srst_n)
        `CHK("mid_float", 1'b1, pfloat)
        `CHK("mid_ad_low", 1'b1, adlow)
        @(posedge clk);
        rst_n <= 1'b1;
        watch_release(80);
        `CHK("mid_ready_delay", 1'b1, rdy >= 16 && rdy <= 17)
        rd_reg(REG_CMASK, rv);
        `CHK("mid_mask", 32'h2AC3, rv)
        complete_run();
    end
endmodule
